/* core/ifel_pkg.sv */
// Package of the interrupt flag and enable block: register offsets,
// field positions, reset values and the bus carrier structs.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word each.
package ifel_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CORE_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PERIPH_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PERIPH_FLAG = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EDGE_CFG = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PIN_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h18;

  // Core interrupt control fields
  localparam int CC_GLOBAL_EN = 7;
  localparam int CC_PERIPH_GATE = 6;
  localparam int CC_T0_EN = 5;
  localparam int CC_EXT_EN = 4;
  localparam int CC_PORT_EN = 3;
  localparam int CC_T0_FLAG = 2;
  localparam int CC_EXT_FLAG = 1;
  localparam int CC_PORT_FLAG = 0;

  // Peripheral enable and flag fields (same layout)
  localparam int PF_EEPROM = 7;
  localparam int PF_LOW_VOLT = 6;
  localparam int PF_CIPHER = 5;
  localparam int PF_CMP_B = 4;
  localparam int PF_CMP_A = 3;
  localparam int PF_OSC_FAIL = 2;
  localparam int PF_TIMER1 = 0;
  localparam logic [7:0] PF_IMPL_MASK = 8'hFD;

  // Edge configuration field
  localparam int EC_EDGE_SEL = 6;

  // Event status bit positions
  localparam int EV_TIMER0 = 0;
  localparam int EV_EXT_PIN = 1;
  localparam int EV_PORT = 2;
  localparam int EV_EEPROM = 3;
  localparam int EV_LOW_VOLT = 4;
  localparam int EV_CIPHER = 5;
  localparam int EV_CMP_A = 6;
  localparam int EV_CMP_B = 7;
  localparam int EV_OSC_FAIL = 8;
  localparam int EV_TIMER1 = 9;
  localparam int EV_W = 10;

  // Reset values
  localparam logic [7:0] RST_CORE_CTRL = 8'h00;
  localparam logic [7:0] RST_PERIPH_EN = 8'h00;
  localparam logic [7:0] RST_PERIPH_FLAG = 8'h00;
  localparam logic [7:0] RST_EDGE_CFG = 8'h40;
  localparam logic [EV_W-1:0] RST_EVT = 10'h000;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } ifel_bus_req_s;

  typedef struct packed {
    logic waitrequest;
    logic [DATA_W-1:0] readdata;
  } ifel_bus_rsp_s;

  // Same-clock one-cycle event pulses from on-chip sources
  typedef struct packed {
    logic timer0Rollover;
    logic ultraLowPowerWakeup;
    logic eepromWriteDone;
    logic lowVoltageDetect;
    logic cipherDone;
    logic oscFail;
    logic timer1Rollover;
  } ifel_pulse_s;

endpackage

/* core/ifel_top.sv */
// Interrupt flag and enable logic: core control, peripheral enable and
// flag registers, event status with mask, and the request to the core.
// Assumes a single 200 MHz clock; pins and comparator outputs are async,
// event pulses come from same-clock logic and last one cycle.
//
// Functional notes
// R01: Flags set regardless of any enable
// R02: Global enable gates every core request
// R03: Peripheral gate gates all peripheral sources
// R04: Timer0 rollover sets sticky flag bit 2
// R05: External edge sets sticky flag bit 1
// R06: Any masked port pin change sets flag bit 0
// R07: Port change needs per-pin mask; includes wakeup
// R08: Peripheral bit 1 reads zero, ignores writes
// R09: EEPROM write done sets peripheral bit 7
// R10: Low-voltage crossing sets peripheral bit 6
// R11: Cipher completion sets peripheral bit 5
// R12: Comparator output change sets bit 3/4
// R13: Oscillator failure sets peripheral bit 2
// R14: Timer1 rollover sets peripheral bit 0
// R15: Software clears flags before enabling
// R16: Software initialises timer0 before clearing flag
// R17: Edge select 1 rising, 0 falling
// R18: Request equals gated OR of flag-enable pairs
`timescale 1ns/100ps
`default_nettype none

module ifel_top #(
  parameter int PORT_W = 6,
  parameter bit HAS_CMP_B = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire ifel_pkg::ifel_bus_req_s busReq,
  output ifel_pkg::ifel_bus_rsp_s busRsp,
  input wire ifel_pkg::ifel_pulse_s evtPulse,
  input wire logic externalInterruptPin,
  input wire logic [PORT_W-1:0] gpPort,
  input wire logic comparatorAOutput,
  input wire logic comparatorBOutput,
  output logic coreIrqReq,
  output logic irqOut
);

  localparam int PIN_W = PORT_W + 3;

  logic [1:0] rstSync_ff;
  logic rstN;

  logic [PIN_W-1:0] pinMeta_ff;
  logic [PIN_W-1:0] pinSync_ff;
  logic [PIN_W-1:0] pinPrev_ff;
  logic [PIN_W-1:0] pinRaw;

  logic waitReq_ff;
  logic [ifel_pkg::DATA_W-1:0] readData_ff;
  logic [ifel_pkg::DATA_W-1:0] nxt_readData;
  logic accept;
  logic wrAck;
  logic rdAck;

  logic [7:0] coreCtrl_ff;
  logic [7:0] periphEn_ff;
  logic [7:0] periphFlag_ff;
  logic [7:0] edgeCfg_ff;
  logic [PORT_W-1:0] pinMask_ff;
  logic [ifel_pkg::EV_W-1:0] evtStatus_ff;
  logic [ifel_pkg::EV_W-1:0] evtMask_ff;
  logic coreIrqReq_ff;
  logic irqOut_ff;

  logic extNow;
  logic extPrev;
  logic extEvent;
  logic [PORT_W-1:0] portChange;
  logic portEvent;
  logic cmpAEvent;
  logic cmpBEvent;
  logic [7:0] periphSet;
  logic [2:0] coreSet;
  logic [ifel_pkg::EV_W-1:0] evtVec;
  logic [ifel_pkg::EV_W-1:0] evtRdClear;
  logic wrCore;
  logic wrPeriphEn;
  logic wrPeriphFlag;
  logic [7:0] wByte;
  logic wrEdgeCfg;
  logic wrPinMask;
  logic wrEvtMask;
  logic [2:0] pinFill_ff;
  logic pinArmed;
  logic [7:0] nxt_coreCtrl;
  logic [7:0] nxt_periphFlag;
  logic coreReqTerm;
  logic periphReqTerm;
  logic nxt_coreIrqReq;
  logic nxt_irqOut;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_ff <= 2'h0;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstN = rstSync_ff[1];

  // Async pins: two flops, then a third copy for edge detection
  assign pinRaw = {comparatorBOutput, comparatorAOutput, gpPort,
                   externalInterruptPin};

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
    end else begin
      pinMeta_ff <= pinRaw;
      pinSync_ff <= pinMeta_ff;
    end
  end

  // Compare copy for change and edge detection
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinPrev_ff <= '0;
    end else begin
      pinPrev_ff <= pinSync_ff;
    end
  end

  // Compares wait for a real sample in both copies, so a pin that
  // idles high gives no false event after reset
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinFill_ff <= 3'h0;
    end else begin
      pinFill_ff <= {pinFill_ff[1:0], 1'b1};
    end
  end
  assign pinArmed = pinFill_ff[2];

  assign extNow = pinSync_ff[0];
  assign extPrev = pinPrev_ff[0];

  // R17 edge polarity
  always_comb begin
    if (edgeCfg_ff[ifel_pkg::EC_EDGE_SEL]) begin
      extEvent = pinArmed & extNow & ~extPrev;
    end else begin
      extEvent = pinArmed & ~extNow & extPrev;
    end
  end

  // R07 masked pins plus wakeup
  assign portChange = (pinSync_ff[PORT_W:1] ^ pinPrev_ff[PORT_W:1])
                      & pinMask_ff & {PORT_W{pinArmed}};
  assign portEvent = (|portChange) | evtPulse.ultraLowPowerWakeup;

  // R12 comparator output change
  assign cmpAEvent = pinArmed &
                     (pinSync_ff[PORT_W+1] ^ pinPrev_ff[PORT_W+1]);
  assign cmpBEvent = HAS_CMP_B & pinArmed &
                     (pinSync_ff[PORT_W+2] ^ pinPrev_ff[PORT_W+2]);

  // R01 set terms carry no enable
  always_comb begin
    coreSet = 3'h0;
    // R04 timer0 rollover
    coreSet[ifel_pkg::CC_T0_FLAG] = evtPulse.timer0Rollover;
    // R05 selected pin edge
    coreSet[ifel_pkg::CC_EXT_FLAG] = extEvent;
    // R06 port pin change
    coreSet[ifel_pkg::CC_PORT_FLAG] = portEvent;
  end

  always_comb begin
    periphSet = 8'h00;
    // R09 write complete
    periphSet[ifel_pkg::PF_EEPROM] = evtPulse.eepromWriteDone;
    // R10 voltage crossing
    periphSet[ifel_pkg::PF_LOW_VOLT] = evtPulse.lowVoltageDetect;
    // R11 cipher completion
    periphSet[ifel_pkg::PF_CIPHER] = evtPulse.cipherDone;
    // R12 comparator output change
    periphSet[ifel_pkg::PF_CMP_B] = cmpBEvent;
    periphSet[ifel_pkg::PF_CMP_A] = cmpAEvent;
    // R13 oscillator failure
    periphSet[ifel_pkg::PF_OSC_FAIL] = evtPulse.oscFail;
    // R14 timer1 rollover
    periphSet[ifel_pkg::PF_TIMER1] = evtPulse.timer1Rollover;
  end

  always_comb begin
    evtVec = '0;
    evtVec[ifel_pkg::EV_TIMER0] = evtPulse.timer0Rollover;
    evtVec[ifel_pkg::EV_EXT_PIN] = extEvent;
    evtVec[ifel_pkg::EV_PORT] = portEvent;
    evtVec[ifel_pkg::EV_EEPROM] = evtPulse.eepromWriteDone;
    evtVec[ifel_pkg::EV_LOW_VOLT] = evtPulse.lowVoltageDetect;
    evtVec[ifel_pkg::EV_CIPHER] = evtPulse.cipherDone;
    evtVec[ifel_pkg::EV_CMP_A] = cmpAEvent;
    evtVec[ifel_pkg::EV_CMP_B] = cmpBEvent;
    evtVec[ifel_pkg::EV_OSC_FAIL] = evtPulse.oscFail;
    evtVec[ifel_pkg::EV_TIMER1] = evtPulse.timer1Rollover;
  end

  // Bus handshake: one wait cycle, then one acknowledge cycle
  assign accept = (busReq.read | busReq.write) & waitReq_ff;
  assign wrAck = busReq.write & ~waitReq_ff;
  assign rdAck = busReq.read & ~waitReq_ff;
  assign wByte = busReq.writedata[7:0];
  assign wrCore = wrAck & (busReq.address == ifel_pkg::OFS_CORE_CTRL);
  assign wrPeriphEn = wrAck & (busReq.address == ifel_pkg::OFS_PERIPH_EN);
  assign wrPeriphFlag = wrAck &
                        (busReq.address == ifel_pkg::OFS_PERIPH_FLAG);
  assign wrEdgeCfg = wrAck & (busReq.address == ifel_pkg::OFS_EDGE_CFG);
  assign wrPinMask = wrAck & (busReq.address == ifel_pkg::OFS_PIN_MASK);
  assign wrEvtMask = wrAck & (busReq.address == ifel_pkg::OFS_EVT_MASK);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      waitReq_ff <= 1'b1;
    end else begin
      waitReq_ff <= ~accept;
    end
  end

  // Unmapped offsets read as zero
  always_comb begin
    nxt_readData = '0;
    unique case (busReq.address)
      ifel_pkg::OFS_CORE_CTRL: nxt_readData[7:0] = coreCtrl_ff;
      ifel_pkg::OFS_PERIPH_EN: nxt_readData[7:0] = periphEn_ff;
      ifel_pkg::OFS_PERIPH_FLAG: nxt_readData[7:0] = periphFlag_ff;
      ifel_pkg::OFS_EDGE_CFG: nxt_readData[7:0] = edgeCfg_ff;
      ifel_pkg::OFS_PIN_MASK: nxt_readData[PORT_W-1:0] = pinMask_ff;
      ifel_pkg::OFS_EVT_STATUS: begin
        nxt_readData[ifel_pkg::EV_W-1:0] = evtStatus_ff;
      end
      ifel_pkg::OFS_EVT_MASK: begin
        nxt_readData[ifel_pkg::EV_W-1:0] = evtMask_ff;
      end
      default: nxt_readData = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      readData_ff <= '0;
    end else if (accept) begin
      readData_ff <= busReq.read ? nxt_readData : '0;
    end
  end

  // R04 R05 R06 sticky, set wins over a software clear
  always_comb begin
    nxt_coreCtrl = coreCtrl_ff;
    if (wrCore) begin
      nxt_coreCtrl = wByte;
    end
    nxt_coreCtrl = nxt_coreCtrl | {5'h00, coreSet};
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      coreCtrl_ff <= ifel_pkg::RST_CORE_CTRL;
    end else begin
      coreCtrl_ff <= nxt_coreCtrl;
    end
  end

  // R08 unimplemented bit masked on write
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      periphEn_ff <= ifel_pkg::RST_PERIPH_EN;
    end else if (wrPeriphEn) begin
      periphEn_ff <= wByte & ifel_pkg::PF_IMPL_MASK;
    end
  end

  // R09 R10 R11 R13 R14 sticky peripheral flags
  always_comb begin
    nxt_periphFlag = periphFlag_ff;
    if (wrPeriphFlag) begin
      nxt_periphFlag = wByte;
    end
    nxt_periphFlag = (nxt_periphFlag | periphSet) & ifel_pkg::PF_IMPL_MASK;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      periphFlag_ff <= ifel_pkg::RST_PERIPH_FLAG;
    end else begin
      periphFlag_ff <= nxt_periphFlag;
    end
  end

  // Only the edge select bit is kept
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      edgeCfg_ff <= ifel_pkg::RST_EDGE_CFG;
    end else if (wrEdgeCfg) begin
      edgeCfg_ff <= wByte & ifel_pkg::RST_EDGE_CFG;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinMask_ff <= '0;
    end else if (wrPinMask) begin
      pinMask_ff <= busReq.writedata[PORT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      evtMask_ff <= ifel_pkg::RST_EVT;
    end else if (wrEvtMask) begin
      evtMask_ff <= busReq.writedata[ifel_pkg::EV_W-1:0];
    end
  end

  // Only bits already shown to software are cleared by the read
  always_comb begin
    evtRdClear = '0;
    if (rdAck && busReq.address == ifel_pkg::OFS_EVT_STATUS) begin
      evtRdClear = readData_ff[ifel_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      evtStatus_ff <= ifel_pkg::RST_EVT;
    end else begin
      evtStatus_ff <= (evtStatus_ff & ~evtRdClear) | evtVec;
    end
  end

  // R18 core flag-enable pairs
  assign coreReqTerm =
    |(coreCtrl_ff[ifel_pkg::CC_T0_EN:ifel_pkg::CC_PORT_EN] &
      coreCtrl_ff[ifel_pkg::CC_T0_FLAG:ifel_pkg::CC_PORT_FLAG]);
  // R03 peripheral gate
  assign periphReqTerm = coreCtrl_ff[ifel_pkg::CC_PERIPH_GATE] &
                         (|(periphEn_ff & periphFlag_ff));
  // R02 global enable over both
  assign nxt_coreIrqReq = coreCtrl_ff[ifel_pkg::CC_GLOBAL_EN] &
                          (coreReqTerm | periphReqTerm);
  assign nxt_irqOut = |(evtStatus_ff & evtMask_ff);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      coreIrqReq_ff <= 1'b0;
    end else begin
      coreIrqReq_ff <= nxt_coreIrqReq;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqOut_ff <= 1'b0;
    end else begin
      irqOut_ff <= nxt_irqOut;
    end
  end

  assign busRsp.waitrequest = waitReq_ff;
  assign busRsp.readdata = readData_ff;
  assign coreIrqReq = coreIrqReq_ff;
  assign irqOut = irqOut_ff;

endmodule // ifel_top

`default_nettype wire

/* verif/ifel_checker.sv */
// Bus and request checks on the top ports of the interrupt block.
// Assumes one clock; requests start after the reset release chain.
`timescale 1ns/100ps
`default_nettype none
module ifel_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire ifel_pkg::ifel_bus_req_s busReq,
  input wire ifel_pkg::ifel_bus_rsp_s busRsp,
  input wire ifel_pkg::ifel_pulse_s evtPulse,
  input wire logic coreIrqReq
);
  logic [7:0] ctrl_ff;
  logic [7:0] pen_ff;
  logic wrAck;
  logic rdAck;
  assign wrAck = busReq.write && !busRsp.waitrequest;
  assign rdAck = busReq.read && !busRsp.waitrequest;
  // Shadow enables, so requests can be tied to their gates
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= 8'h00;
    end else if (wrAck && busReq.address == ifel_pkg::OFS_CORE_CTRL) begin
      ctrl_ff <= busReq.writedata[7:0];
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pen_ff <= 8'h00;
    end else if (wrAck && busReq.address == ifel_pkg::OFS_PERIPH_EN) begin
      pen_ff <= busReq.writedata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence reqWait;
    (busReq.read || busReq.write) && busRsp.waitrequest;
  endsequence
  sequence reqDone;
    !busRsp.waitrequest ##1 busRsp.waitrequest;
  endsequence
  chk_wait_one: assert property (reqWait |=> reqDone)
    else $error("bus answer not after one wait cycle");
  chk_gie_gate: assert property (!ctrl_ff[7] |=> !coreIrqReq)
    else $error("request while global enable off");
  chk_t0_req: assert property (evtPulse.timer0Rollover && ctrl_ff[7]
    && ctrl_ff[5] && !busReq.write |-> ##2 coreIrqReq)
    else $error("timer0 rollover gave no request");
  chk_ee_req: assert property (evtPulse.eepromWriteDone && ctrl_ff[7]
    && ctrl_ff[6] && pen_ff[7] && !busReq.write |-> ##2 coreIrqReq)
    else $error("eeprom done gave no request");
  chk_rise_cause: assert property (!(ctrl_ff[7] && ctrl_ff[6:3] != 4'h0)
    |=> !$rose(coreIrqReq))
    else $error("request rose without an enable");
  chk_bit1_zero: assert property (rdAck && (busReq.address ==
    ifel_pkg::OFS_PERIPH_EN || busReq.address == ifel_pkg::OFS_PERIPH_FLAG)
    |-> busRsp.readdata[1] == 1'b0)
    else $error("peripheral bit 1 read as one");
  chk_unmapped: assert property (rdAck && busReq.address == 8'h1C
    |-> busRsp.readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_high_zero: assert property (rdAck && busReq.address <= 8'h0C
    |-> busRsp.readdata[31:8] == 24'h0)
    else $error("register upper bits not zero");
endmodule // ifel_checker
bind ifel_top ifel_checker u_chk (.clk(clk), .rst_b(rst_b),
  .busReq(busReq), .busRsp(busRsp), .evtPulse(evtPulse),
  .coreIrqReq(coreIrqReq));
`default_nettype wire

/* verif/ifel_src_model.sv */
// On-chip event sources: one-cycle same-clock pulses on request.
// Assumes the caller starts just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module ifel_src_model (
  input wire logic clk,
  output ifel_pkg::ifel_pulse_s evtPulse
);
  initial evtPulse = '0;
  // wakeup pulse shares the port source
  task automatic fire(input ifel_pkg::ifel_pulse_s p);
    @(posedge clk);
    evtPulse <= p;
    @(posedge clk);
    evtPulse <= '0;
  endtask
endmodule // ifel_src_model
`default_nettype wire

/* verif/interrupt_flag_enable_logic_tb.sv */
// Register-level bench of the interrupt block over Avalon-MM.
// Assumes the source model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module interrupt_flag_enable_logic_tb;
  logic clk;
  logic rst_b;
  ifel_pkg::ifel_bus_req_s busReq;
  ifel_pkg::ifel_bus_rsp_s busRsp;
  ifel_pkg::ifel_pulse_s evtPulse;
  logic extPin;
  logic [5:0] gpPort;
  logic cmpA;
  logic cmpB;
  logic coreIrqReq;
  logic irqOut;
  logic [31:0] q;
  int n_fail;
  int tests_run;
  ifel_top u_dut (.clk(clk), .rst_b(rst_b), .busReq(busReq),
    .busRsp(busRsp), .evtPulse(evtPulse), .externalInterruptPin(extPin),
    .gpPort(gpPort), .comparatorAOutput(cmpA), .comparatorBOutput(cmpB),
    .coreIrqReq(coreIrqReq), .irqOut(irqOut));
  ifel_src_model u_src (.clk(clk), .evtPulse(evtPulse));
  task automatic end_sim();
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmpb(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t line got %b exp %b", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    busReq.read <= !w;
    busReq.write <= w;
    busReq.address <= a;
    busReq.writedata <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (busRsp.waitrequest !== 1'b0 && k < 50);
    if (busRsp.waitrequest !== 1'b0) begin
      n_fail++;
      $display("[ERR] %0t bus answer timed out", $time);
      end_sim();
    end else begin
      q = busRsp.readdata;
      busReq.read <= 1'b0;
      busReq.write <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
    repeat (2) @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    cmp(q, exp);
  endtask
  task automatic ev(input logic [6:0] p);
    u_src.fire(p);
    repeat (2) @(posedge clk);
  endtask
  // Sync flops plus compare flop need three edges
  task automatic pins(input logic e, input logic [5:0] g, input logic c);
    @(posedge clk);
    extPin <= e;
    gpPort <= g;
    cmpA <= c;
    cmpB <= c;
    repeat (5) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    n_fail++;
    $display("[ERR] %0t run timed out", $time);
    end_sim();
  end
  initial begin
    rst_b = 1'b0;
    busReq = '0;
    extPin = 1'b0;
    gpPort = 6'h00;
    cmpA = 1'b0;
    cmpB = 1'b0;
    n_fail = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(ifel_pkg::OFS_EDGE_CFG, 32'h40);
    rdc(8'h1C, 32'h0);
    ev(7'h7F);
    pins(1'b1, 6'h3F, 1'b1);
    rdc(ifel_pkg::OFS_PERIPH_FLAG, 32'hFD);
    rdc(ifel_pkg::OFS_CORE_CTRL, 32'h07);
    cmpb(coreIrqReq, 1'b0);
    cmpb(irqOut, 1'b0);
    rdc(ifel_pkg::OFS_EVT_STATUS, 32'h3FF);
    rdc(ifel_pkg::OFS_EVT_STATUS, 32'h0);
    wr(ifel_pkg::OFS_CORE_CTRL, 32'h0);
    wr(ifel_pkg::OFS_PIN_MASK, 32'h01);
    pins(1'b1, 6'h3D, 1'b1);
    rdc(ifel_pkg::OFS_CORE_CTRL, 32'h0);
    pins(1'b1, 6'h3C, 1'b1);
    rdc(ifel_pkg::OFS_CORE_CTRL, 32'h01);
    wr(ifel_pkg::OFS_EDGE_CFG, 32'h0);
    pins(1'b0, 6'h3C, 1'b1);
    rdc(ifel_pkg::OFS_CORE_CTRL, 32'h03);
    wr(ifel_pkg::OFS_CORE_CTRL, 32'h0);
    pins(1'b1, 6'h3C, 1'b1);
    rdc(ifel_pkg::OFS_CORE_CTRL, 32'h0);
    wr(ifel_pkg::OFS_PERIPH_EN, 32'hFF);
    rdc(ifel_pkg::OFS_PERIPH_EN, 32'hFD);
    wr(ifel_pkg::OFS_PERIPH_FLAG, 32'h02);
    rdc(ifel_pkg::OFS_PERIPH_FLAG, 32'h0);
    wr(ifel_pkg::OFS_PERIPH_EN, 32'h80);
    wr(ifel_pkg::OFS_CORE_CTRL, 32'h20);
    ev(7'h40);
    cmpb(coreIrqReq, 1'b0);
    wr(ifel_pkg::OFS_CORE_CTRL, 32'hA0);
    ev(7'h40);
    cmpb(coreIrqReq, 1'b1);
    wr(ifel_pkg::OFS_CORE_CTRL, 32'h80);
    ev(7'h10);
    cmpb(coreIrqReq, 1'b0);
    wr(ifel_pkg::OFS_CORE_CTRL, 32'hC0);
    cmpb(coreIrqReq, 1'b1);
    wr(ifel_pkg::OFS_PERIPH_FLAG, 32'h0);
    cmpb(coreIrqReq, 1'b0);
    ev(7'h10);
    cmpb(coreIrqReq, 1'b1);
    rdc(ifel_pkg::OFS_EVT_STATUS, 32'h00F);
    wr(ifel_pkg::OFS_EVT_MASK, 32'h008);
    ev(7'h10);
    cmpb(irqOut, 1'b1);
    rdc(ifel_pkg::OFS_EVT_STATUS, 32'h008);
    repeat (2) @(posedge clk);
    cmpb(irqOut, 1'b0);
    ev(7'h08);
    cmpb(irqOut, 1'b0);
    rdc(ifel_pkg::OFS_EVT_STATUS, 32'h010);
    end_sim();
  end
endmodule // interrupt_flag_enable_logic_tb
`default_nettype wire
